// File: hw/uart_lmc_pkg.sv
// Constants, state type and shared helpers for the serial line block.
package uart_lmc_pkg;
   localparam logic [2:0] OFS_DATA    = 3'h0;
   localparam logic [2:0] OFS_IER     = 3'h1;
   localparam logic [2:0] OFS_IDENT   = 3'h2;
   localparam logic [2:0] OFS_FORMAT  = 3'h3;
   localparam logic [2:0] OFS_MODEM   = 3'h4;
   localparam logic [2:0] OFS_LSR     = 3'h5;
   localparam logic [2:0] OFS_MSR     = 3'h6;
   localparam logic [2:0] OFS_SCRATCH = 3'h7;
   localparam int DIVISOR_ACCESS_SELECT_BIT  = 7;
   localparam int BREAK_BIT = 6;
   localparam int STICK_BIT = 5;
   localparam int EVEN_BIT  = 4;
   localparam int PAREN_BIT = 3;
   localparam int STOP_BIT  = 2;
   localparam int DTR_BIT   = 0;
   localparam int RTS_BIT   = 1;
   localparam int USER_OUTPUT_ONE_BIT  = 2;
   localparam int INTERRUPT_GATE_OUTPUT_BIT  = 3;
   localparam int LOOP_BIT  = 4;
   localparam int IE_RX     = 0;
   localparam int IE_HOLDING_EMPTY_FLAG   = 1;
   localparam int IE_LINE   = 2;
   localparam int IE_MODEM  = 3;
   localparam int FC_EN     = 0;
   localparam int FC_RXCLR  = 1;
   localparam logic [3:0] ID_NONE    = 4'h1;
   localparam logic [3:0] ID_LINE    = 4'h6;
   localparam logic [3:0] ID_RXDATA  = 4'h4;
   localparam logic [3:0] ID_TIMEOUT = 4'hc;
   localparam logic [3:0] ID_HOLDING_EMPTY_FLAG    = 4'h2;
   localparam logic [3:0] ID_MODEM   = 4'h0;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [4:0]  RST_MCR  = 5'h00;
   localparam logic [15:0] RST_DIV  = 16'h0001;
   localparam logic [5:0] BIT_TICKS    = 6'h10;
   localparam logic [5:0] HALF_TICKS   = 6'h08;
   localparam logic [5:0] STOP15_TICKS = 6'h18;
   localparam logic [5:0] STOP2_TICKS  = 6'h20;
   localparam int TIMEOUT_CHARS = 4;
   localparam int OVERSAMPLE    = 16;
   localparam int TRIG_4  = 4;
   localparam int TRIG_8  = 8;
   localparam int TRIG_14 = 14;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_START  = 3'b001,
      S_DATA   = 3'b011,
      S_PARITY = 3'b010,
      S_STOP   = 3'b110
   } ser_state_t;

   function automatic logic [2:0] last_bit(input logic [7:0] fmt);
      return 3'(3'h4 + {1'b0, fmt[1:0]});
   endfunction : last_bit

   function automatic logic parity_of(input logic [7:0] d,
                                      input logic [7:0] fmt);
      logic [7:0] m;
      m = d & (8'hff >> (3'h3 - {1'b0, fmt[1:0]}));
      if (fmt[STICK_BIT])
         return ~fmt[EVEN_BIT];
      return fmt[EVEN_BIT] ? ^m : ~^m;
   endfunction : parity_of

   function automatic logic [3:0] char_bits(input logic [7:0] fmt);
      return 4'(4'h6 + {2'b00, fmt[1:0]} + {3'b000, fmt[PAREN_BIT]}
                + {3'b000, fmt[STOP_BIT]});
   endfunction : char_bits

   function automatic ser_state_t next_state(input ser_state_t st,
                                             input logic [2:0] idx,
                                             input logic [7:0] fmt);
      case (st)
         S_START:  return S_DATA;
         S_DATA:   return (idx != last_bit(fmt)) ? S_DATA :
                          (fmt[PAREN_BIT] ? S_PARITY : S_STOP);
         S_PARITY: return S_STOP;
         default:  return S_IDLE;
      endcase
   endfunction : next_state
endpackage : uart_lmc_pkg

// File: hw/uart_line_modem_control.sv
// Serial port core: registers, interrupt identification, framing, modem.
//
// Contract
// - Identification bits 4 and 5 always read zero.
// - Identification bits 6 and 7 mirror the FIFO enable bit.
// - Source codes by priority; line and modem clear on their reads.
// - Data interrupt clears on buffer read or count below trigger.
// - Timeout after four idle character times with data held; read clears.
// - Holding empty clears on identification read as source or write.
// - Format bits 1:0 give five to eight data bits.
// - Stop bits: one, or 1.5 for five bits, else two.
// - Receiver checks only the first stop bit.
// - Parity bit sits after data, before stop, both directions.
// - Format bit 4 low gives odd parity, high gives even.
// - Stick parity sends and expects inverse of format bit 4.
// - Break bit holds transmit output at spacing.
// - Format bit 7 steers offsets 0 and 1 to divisor bytes.
// - Terminal ready pin is inverse of modem control bit 0.
// - Send request pin is inverse of modem control bit 1.
// - Modem control bit 2 has no pin; it only feeds ring indicate in loopback.
// - Interrupt pin enabled only while modem control bit 3 set.
// - Loopback marks transmit pin, ignores receive pin, loops data.
// - Loopback feeds modem outputs to inputs; terminal ready and send request pins inactive.
// - Loopback modem interrupts come from control bits, still enabled.
// - Modem control bits 5 to 7 read zero.
// - Identification bit 0 low while an interrupt is pending.
// - Identification value is held steady across its read.
// - Modem status change bits clear on modem status read.
module uart_line_modem_control #(
   parameter int RX_DEPTH = 16
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   input  wire logic       rxd,
   input  wire logic       clear_to_send_in_n,
   input  wire logic       data_set_ready_in_n,
   input  wire logic       ring_in_n,
   input  wire logic       carrier_detect_in_n,
   output logic      [7:0] rdata,
   output logic            txd,
   output logic            terminal_ready_out_n,
   output logic            send_request_out_n,
   output logic            serial_irq,
   output logic            serial_irq_oe
);
   localparam int AW = $clog2(RX_DEPTH);
   if (RX_DEPTH < 16 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_chk
      $error("RX_DEPTH must be a power of two, at least 16");
   end

   logic [7:0]  ier_r, fmt_r, scr_r, dll_r, dlh_r, thr_r;
   logic [4:0]  mcr_r;
   logic        fifo_en_r, thr_full_r, holding_empty_flag_int_r, to_flag_r;
   logic [1:0]  trig_sel_r;
   logic [15:0] baud_cnt_r;
   logic        lsr_oe_r, lsr_pe_r, lsr_fe_r, lsr_bi_r;
   logic [3:0]  mdm_prev_r, delta_r;
   logic [9:0]  to_cnt_r;
   uart_lmc_pkg::ser_state_t tx_st_r, rx_st_r;
   logic [7:0]  tx_sh_r, rx_sh_r;
   logic [2:0]  tx_idx_r, rx_idx_r;
   logic [5:0]  tx_tk_r, rx_tk_r;
   logic        tx_par_r, rx_par_r;
   logic [7:0]  rx_mem [RX_DEPTH];
   logic [AW-1:0] rx_wp_r, rx_rp_r;
   logic [AW:0]   rx_cnt_r;

   // Offsets 0 and 1 change meaning with the access select bit.
   wire divisor_access_select   = fmt_r[uart_lmc_pkg::DIVISOR_ACCESS_SELECT_BIT];
   wire loop   = mcr_r[uart_lmc_pkg::LOOP_BIT];
   wire brk    = fmt_r[uart_lmc_pkg::BREAK_BIT];
   wire a_data = addr == uart_lmc_pkg::OFS_DATA;
   wire a_ier  = addr == uart_lmc_pkg::OFS_IER;
   wire wr_thr = wr_en & a_data & ~divisor_access_select;
   wire wr_dll = wr_en & a_data & divisor_access_select;
   wire wr_ier = wr_en & a_ier & ~divisor_access_select;
   wire wr_dlh = wr_en & a_ier & divisor_access_select;
   wire wr_fcr = wr_en & (addr == uart_lmc_pkg::OFS_IDENT);
   wire wr_fmt = wr_en & (addr == uart_lmc_pkg::OFS_FORMAT);
   wire wr_mcr = wr_en & (addr == uart_lmc_pkg::OFS_MODEM);
   wire wr_scr = wr_en & (addr == uart_lmc_pkg::OFS_SCRATCH);
   wire rd_rbr = rd_en & a_data & ~divisor_access_select;
   wire rd_iir = rd_en & (addr == uart_lmc_pkg::OFS_IDENT);
   wire rd_lsr = rd_en & (addr == uart_lmc_pkg::OFS_LSR);
   wire rd_msr = rd_en & (addr == uart_lmc_pkg::OFS_MSR);

   // A zero divisor is served as one rather than stalling the port.
   wire [15:0] div    = {dlh_r, dll_r};
   wire [15:0] div_m1 = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
   wire        tick   = baud_cnt_r == 16'h0000;

   wire [5:0] stop_ticks = !fmt_r[uart_lmc_pkg::STOP_BIT] ?
      uart_lmc_pkg::BIT_TICKS : (fmt_r[1:0] == 2'b00) ?
      uart_lmc_pkg::STOP15_TICKS : uart_lmc_pkg::STOP2_TICKS;
   wire [5:0] tx_len = (tx_st_r == uart_lmc_pkg::S_STOP) ? stop_ticks :
                       uart_lmc_pkg::BIT_TICKS;
   wire tx_end  = tick & (tx_tk_r == tx_len - 6'h01);
   wire tx_load = (tx_st_r == uart_lmc_pkg::S_IDLE) & thr_full_r;
   wire tx_line = (tx_st_r == uart_lmc_pkg::S_START)  ? 1'b0 :
                  (tx_st_r == uart_lmc_pkg::S_DATA)   ? tx_sh_r[0] :
                  (tx_st_r == uart_lmc_pkg::S_PARITY) ? tx_par_r :
                  1'b1;
   // Loopback takes the serial line before the pin, break included.
   wire rx_in = loop ? (tx_line & ~brk) : rxd;
   wire rx_sample = tick & (rx_tk_r == uart_lmc_pkg::BIT_TICKS - 6'h01);
   wire rx_mid = tick & (rx_tk_r == uart_lmc_pkg::HALF_TICKS - 6'h01);
   wire rx_done = (rx_st_r == uart_lmc_pkg::S_STOP) & rx_sample;
   wire [7:0] rx_word = rx_sh_r >> (3'h3 - {1'b0, fmt_r[1:0]});
   wire rx_pe = fmt_r[uart_lmc_pkg::PAREN_BIT] &
                (rx_par_r != uart_lmc_pkg::parity_of(rx_word, fmt_r));
   wire rx_fe = ~rx_in;
   wire rx_bi = (rx_word == 8'h00) & ~rx_in &
                (~fmt_r[uart_lmc_pkg::PAREN_BIT] | ~rx_par_r);

   wire [AW:0] cap = fifo_en_r ? (AW+1)'(RX_DEPTH) : (AW+1)'(1);
   wire rx_full = rx_cnt_r == cap;
   wire push    = rx_done & ~rx_full;
   wire pop     = rd_rbr & (rx_cnt_r != '0);
   wire rx_clr  = wr_fcr & (wdata[uart_lmc_pkg::FC_RXCLR] |
                  (wdata[uart_lmc_pkg::FC_EN] != fifo_en_r));
   wire [AW:0] trig = !fifo_en_r ? (AW+1)'(1) :
      (trig_sel_r == 2'b00) ? (AW+1)'(1) :
      (trig_sel_r == 2'b01) ? (AW+1)'(uart_lmc_pkg::TRIG_4) :
      (trig_sel_r == 2'b10) ? (AW+1)'(uart_lmc_pkg::TRIG_8) :
      (AW+1)'(uart_lmc_pkg::TRIG_14);
   wire rx_avail = rx_cnt_r >= trig;
   wire [9:0] to_limit = 10'(uart_lmc_pkg::char_bits(fmt_r) *
      uart_lmc_pkg::TIMEOUT_CHARS * uart_lmc_pkg::OVERSAMPLE);
   wire to_set = fifo_en_r & (rx_cnt_r != '0) & tick &
                 (to_cnt_r == to_limit - 10'h001);

   // Loopback ties outputs back as cts/rts, dsr/dtr, ri/user_output_one, dcd/interrupt_gate_output.
   wire [3:0] mdm_now = loop ?
      {mcr_r[uart_lmc_pkg::INTERRUPT_GATE_OUTPUT_BIT], mcr_r[uart_lmc_pkg::USER_OUTPUT_ONE_BIT],
       mcr_r[uart_lmc_pkg::DTR_BIT], mcr_r[uart_lmc_pkg::RTS_BIT]} :
      {~carrier_detect_in_n, ~ring_in_n, ~data_set_ready_in_n,
       ~clear_to_send_in_n};
   wire [3:0] delta_set = {mdm_now[3] ^ mdm_prev_r[3],
                           mdm_prev_r[2] & ~mdm_now[2],
                           mdm_now[1:0] ^ mdm_prev_r[1:0]};

   wire line_int = ier_r[uart_lmc_pkg::IE_LINE] &
                   (lsr_oe_r | lsr_pe_r | lsr_fe_r | lsr_bi_r);
   wire rxd_int  = ier_r[uart_lmc_pkg::IE_RX] & rx_avail;
   wire to_int   = ier_r[uart_lmc_pkg::IE_RX] & to_flag_r;
   wire holding_empty_flag_int = ier_r[uart_lmc_pkg::IE_HOLDING_EMPTY_FLAG] & holding_empty_flag_int_r;
   wire mdm_int  = ier_r[uart_lmc_pkg::IE_MODEM] & (delta_r != 4'h0);
   wire [3:0] ident_code = line_int ? uart_lmc_pkg::ID_LINE :
                           rxd_int  ? uart_lmc_pkg::ID_RXDATA :
                           to_int   ? uart_lmc_pkg::ID_TIMEOUT :
                           holding_empty_flag_int ? uart_lmc_pkg::ID_HOLDING_EMPTY_FLAG :
                           mdm_int  ? uart_lmc_pkg::ID_MODEM :
                           uart_lmc_pkg::ID_NONE;
   wire [7:0] ident_byte = {fifo_en_r, fifo_en_r, 2'b00,
                            ident_code};
   wire [7:0] lsr_byte = {fifo_en_r & (lsr_pe_r | lsr_fe_r | lsr_bi_r),
                          ~thr_full_r & (tx_st_r == uart_lmc_pkg::S_IDLE),
                          ~thr_full_r, lsr_bi_r, lsr_fe_r, lsr_pe_r,
                          lsr_oe_r, rx_cnt_r != '0};
   wire [7:0] rbr_byte = (rx_cnt_r != '0) ? rx_mem[rx_rp_r] : 8'h00;
   wire [7:0] rd_mux =
      a_data ? (divisor_access_select ? dll_r : rbr_byte) :
      a_ier  ? (divisor_access_select ? dlh_r : ier_r) :
      (addr == uart_lmc_pkg::OFS_IDENT)  ? ident_byte :
      (addr == uart_lmc_pkg::OFS_FORMAT) ? fmt_r :
      (addr == uart_lmc_pkg::OFS_MODEM)  ? {3'b000, mcr_r} :
      (addr == uart_lmc_pkg::OFS_LSR)    ? lsr_byte :
      (addr == uart_lmc_pkg::OFS_MSR)    ? {mdm_now, delta_r} : scr_r;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ier_r <= uart_lmc_pkg::RST_BYTE;
         fmt_r <= uart_lmc_pkg::RST_BYTE;
         scr_r <= uart_lmc_pkg::RST_BYTE;
         mcr_r <= uart_lmc_pkg::RST_MCR;
         {dlh_r, dll_r} <= uart_lmc_pkg::RST_DIV;
         fifo_en_r <= 1'b0;
         trig_sel_r <= 2'b00;
      end else begin
         if (wr_ier) ier_r <= {4'h0, wdata[3:0]};
         if (wr_fmt) fmt_r <= wdata;
         if (wr_scr) scr_r <= wdata;
         if (wr_mcr) mcr_r <= wdata[4:0];
         if (wr_dll) dll_r <= wdata;
         if (wr_dlh) dlh_r <= wdata;
         if (wr_fcr) begin
            fifo_en_r <= wdata[uart_lmc_pkg::FC_EN];
            trig_sel_r <= wdata[7:6];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         baud_cnt_r <= 16'h0000;
         thr_r <= uart_lmc_pkg::RST_BYTE;
         thr_full_r <= 1'b0;
         holding_empty_flag_int_r <= 1'b0;
      end else begin
         baud_cnt_r <= (wr_dll | wr_dlh) ? 16'h0000 :
                       tick ? div_m1 : baud_cnt_r - 16'h0001;
         if (wr_thr) thr_r <= wdata;
         thr_full_r <= wr_thr | (thr_full_r & ~tx_load);
         // The read clears by the value that this same read returns.
         if ((tx_load & ~wr_thr) | (wr_ier & wdata[uart_lmc_pkg::IE_HOLDING_EMPTY_FLAG]
             & ~ier_r[uart_lmc_pkg::IE_HOLDING_EMPTY_FLAG] & ~thr_full_r))
            holding_empty_flag_int_r <= 1'b1;
         else if (wr_thr | (rd_iir & (ident_code == uart_lmc_pkg::ID_HOLDING_EMPTY_FLAG)))
            holding_empty_flag_int_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tx_st_r <= uart_lmc_pkg::S_IDLE;
         tx_sh_r <= 8'h00;
         tx_idx_r <= 3'h0;
         tx_tk_r <= 6'h00;
         tx_par_r <= 1'b0;
      end else if (tx_load) begin
         tx_st_r <= uart_lmc_pkg::S_START;
         tx_sh_r <= thr_r;
         tx_par_r <= uart_lmc_pkg::parity_of(thr_r, fmt_r);
         tx_tk_r <= 6'h00;
         tx_idx_r <= 3'h0;
      end else if (tx_end) begin
         tx_st_r <= uart_lmc_pkg::next_state(tx_st_r, tx_idx_r, fmt_r);
         tx_tk_r <= 6'h00;
         if (tx_st_r == uart_lmc_pkg::S_DATA) begin
            tx_sh_r <= tx_sh_r >> 1;
            tx_idx_r <= tx_idx_r + 3'h1;
         end
      end else if (tick && tx_st_r != uart_lmc_pkg::S_IDLE) begin
         tx_tk_r <= tx_tk_r + 6'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rx_st_r <= uart_lmc_pkg::S_IDLE;
         rx_sh_r <= 8'h00;
         rx_idx_r <= 3'h0;
         rx_tk_r <= 6'h00;
         rx_par_r <= 1'b0;
      end else begin
         case (rx_st_r)
            uart_lmc_pkg::S_IDLE: begin
               rx_tk_r <= 6'h00;
               rx_idx_r <= 3'h0;
               if (!rx_in) rx_st_r <= uart_lmc_pkg::S_START;
            end
            uart_lmc_pkg::S_START: begin
               if (rx_mid) begin
                  rx_tk_r <= 6'h00;
                  rx_st_r <= rx_in ? uart_lmc_pkg::S_IDLE :
                                     uart_lmc_pkg::S_DATA;
               end else if (tick) begin
                  rx_tk_r <= rx_tk_r + 6'h01;
               end
            end
            default: begin
               if (rx_sample) begin
                  rx_tk_r <= 6'h00;
                  rx_st_r <= uart_lmc_pkg::next_state(rx_st_r, rx_idx_r,
                                                      fmt_r);
                  if (rx_st_r == uart_lmc_pkg::S_DATA) begin
                     rx_sh_r <= {rx_in, rx_sh_r[7:1]};
                     rx_idx_r <= rx_idx_r + 3'h1;
                  end
                  if (rx_st_r == uart_lmc_pkg::S_PARITY)
                     rx_par_r <= rx_in;
               end else if (tick) begin
                  rx_tk_r <= rx_tk_r + 6'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (push) rx_mem[rx_wp_r] <= rx_word;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b || rx_clr) begin
         rx_wp_r <= '0;
         rx_rp_r <= '0;
         rx_cnt_r <= '0;
      end else begin
         if (push) rx_wp_r <= (cap == (AW+1)'(1)) ? rx_wp_r : rx_wp_r + 1'b1;
         if (pop) rx_rp_r <= (cap == (AW+1)'(1)) ? rx_rp_r : rx_rp_r + 1'b1;
         rx_cnt_r <= rx_cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         to_cnt_r <= 10'h000;
         to_flag_r <= 1'b0;
         {lsr_oe_r, lsr_pe_r, lsr_fe_r, lsr_bi_r} <= 4'h0;
         mdm_prev_r <= 4'h0;
         delta_r <= 4'h0;
      end else begin
         to_cnt_r <= (push | pop | rx_clr | ~fifo_en_r |
                      rx_cnt_r == '0) ? 10'h000 :
                     (tick && to_cnt_r != to_limit) ? to_cnt_r + 10'h001 :
                     to_cnt_r;
         to_flag_r <= to_set | (to_flag_r & ~rd_rbr & ~rx_clr);
         lsr_oe_r <= (rx_done & rx_full) | (lsr_oe_r & ~rd_lsr);
         lsr_pe_r <= (push & rx_pe) | (lsr_pe_r & ~rd_lsr);
         lsr_fe_r <= (push & rx_fe) | (lsr_fe_r & ~rd_lsr);
         lsr_bi_r <= (push & rx_bi) | (lsr_bi_r & ~rd_lsr);
         mdm_prev_r <= mdm_now;
         delta_r <= (rd_msr ? 4'h0 : delta_r) | delta_set;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata <= 8'h00;
         txd <= 1'b1;
         terminal_ready_out_n <= 1'b1;
         send_request_out_n <= 1'b1;
         serial_irq <= 1'b0;
         serial_irq_oe <= 1'b0;
      end else begin
         if (rd_en) rdata <= rd_mux;
         txd <= loop | (~brk & tx_line);
         terminal_ready_out_n <= loop |
                                 ~mcr_r[uart_lmc_pkg::DTR_BIT];
         send_request_out_n <= loop |
                               ~mcr_r[uart_lmc_pkg::RTS_BIT];
         serial_irq <= ident_code != uart_lmc_pkg::ID_NONE;
         serial_irq_oe <= mcr_r[uart_lmc_pkg::INTERRUPT_GATE_OUTPUT_BIT];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence ident_rd_s;
      rd_en && addr == uart_lmc_pkg::OFS_IDENT;
   endsequence
   ident_zero_a: assert property (ident_rd_s |=> rdata[5:4] == 2'b00)
      else $error("identification bits 5:4 not zero");
   ident_fifo_a: assert property (ident_rd_s |=>
      rdata[7:6] == {2{$past(fifo_en_r)}})
      else $error("identification bits 7:6 do not follow fifo enable");
   ident_line_a: assert property (ident_rd_s and line_int |=>
      rdata[3:0] == uart_lmc_pkg::ID_LINE)
      else $error("line status not reported first");
   ident_none_a: assert property (ident_rd_s and !line_int and !rxd_int
      and !to_int and !holding_empty_flag_int and !mdm_int |=> rdata[0])
      else $error("idle identification bit 0 not set");
   tmo_clear_a: assert property (rd_rbr && !to_set |=> !to_flag_r)
      else $error("timeout not cleared by buffer read");
   holding_empty_flag_clear_a: assert property (wr_thr |=> !holding_empty_flag_int_r)
      else $error("holding empty not cleared by write");
   break_hold_a: assert property (brk && !loop |=> !txd)
      else $error("break does not hold spacing");
   loop_mark_a: assert property (loop |=> txd && terminal_ready_out_n
      && send_request_out_n)
      else $error("loopback pins not inactive");
   dtr_pin_a: assert property (!loop |=>
      terminal_ready_out_n == !$past(mcr_r[uart_lmc_pkg::DTR_BIT]))
      else $error("terminal ready pin wrong");
   msr_clear_a: assert property (rd_msr && delta_set == 4'h0 |=>
      delta_r == 4'h0)
      else $error("change bits survive status read");
   irq_gate_a: assert property (##1 serial_irq_oe ==
      $past(mcr_r[uart_lmc_pkg::INTERRUPT_GATE_OUTPUT_BIT]))
      else $error("interrupt enable pin does not follow gate bit");
endmodule : uart_line_modem_control

// File: verification/serial_peer.sv
// Far-end serial peer: sends frames on rxd, records txd, holds modem lines.
module serial_peer (
   input  wire logic mclk,
   input  wire logic txd,
   output logic      rxd,
   output logic      cts_n,
   output logic      dsr_n,
   output logic      ri_n,
   output logic      dcd_n
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {rxd, cts_n, dsr_n, ri_n, dcd_n} = 5'h1f;
   end

   // Bit 0 (start) goes first; each bit lasts sixteen cycles at divisor 1.
   task automatic send(input logic [11:0] b, input int n);
      for (int k = 0; k < n; k++) begin
         rxd <= b[k];
         repeat (16) @(posedge mclk);
      end
      rxd <= 1'b1;
   endtask : send

   // Sampling on the falling edge keeps clear of the registered output.
   task automatic capture(output logic [255:0] w);
      int t;
      t = 0;
      while (txd !== 1'b0 && t < 3000) begin
         @(negedge mclk);
         t++;
      end
      for (int k = 0; k < 256; k++) begin
         w[k] = txd;
         @(negedge mclk);
      end
   endtask : capture
endmodule : serial_peer

// File: verification/uart_line_modem_control_tb_top.sv
// Self-checking bench for the serial line and modem control block.
module uart_line_modem_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic         mclk, rst_b, wr_en, rd_en, txd, rxd, cts_n, dsr_n;
   logic         ri_n, dcd_n, dtr_n, rts_n, irq, irq_oe;
   logic [2:0]   addr;
   logic [7:0]   wdata, rdata, v, d, serial_line_format;
   logic [255:0] w;
   int           num_errors, total_checks, seed, n, p, len;

   uart_line_modem_control uart_line_modem_control_inst (
      .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rxd(rxd), .clear_to_send_in_n(cts_n),
      .data_set_ready_in_n(dsr_n), .ring_in_n(ri_n),
      .carrier_detect_in_n(dcd_n), .rdata(rdata), .txd(txd),
      .terminal_ready_out_n(dtr_n), .send_request_out_n(rts_n),
      .serial_irq(irq), .serial_irq_oe(irq_oe));
   serial_peer serial_peer_inst (.mclk(mclk), .txd(txd), .rxd(rxd),
      .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] x);
      @(posedge mclk);
      addr  <= a;
      wdata <= x;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] x);
      @(posedge mclk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      x = rdata;
   endtask : rd
   task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] x;
      rd(a, x);
      check(x, exp);
   endtask : rchk
   function automatic logic par(input logic [7:0] x, input logic [7:0] f);
      logic [7:0] m;
      m = x & (8'hff >> (3 - f[1:0]));
      return f[5] ? ~f[4] : (f[4] ? ^m : ~^m);
   endfunction : par
   task automatic results();
      if (num_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // The whole sequence needs about 5000 cycles; this leaves ample room.
   initial begin
      repeat (60000) @(posedge mclk);
      num_errors++;
      results();
   end

   initial begin
      seed = 32'hb63c;
      {rst_b, wr_en, rd_en, addr, wdata} = '0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      check({txd, dtr_n, rts_n, irq_oe, irq, 3'h0}, 8'he0);
      rchk(3'h2, 8'h01);
      for (int i = 0; i < 6; i++) begin
         v = 8'($random(seed)) & 8'hef;
         wr(3'h4, v);
         rchk(3'h4, v & 8'h0f);
         check({5'h0, dtr_n, rts_n, irq_oe}, {5'h0, ~v[0], ~v[1], v[3]});
      end
      wr(3'h4, 8'h00);
      wr(3'h3, 8'h80);
      wr(3'h0, 8'ha5);
      rchk(3'h0, 8'ha5);
      wr(3'h0, 8'h01);
      wr(3'h3, 8'h00);
      wr(3'h1, 8'hf8);
      rchk(3'h1, 8'h08);
      wr(3'h3, 8'h80);
      rchk(3'h1, 8'h00);
      wr(3'h3, 8'h00);
      rd(3'h6, v);
      wr(3'h1, 8'h02);
      // The interrupt pin is registered one edge behind the enable write.
      @(posedge mclk);
      #1;
      check({7'h0, irq}, 8'h01);
      rchk(3'h2, 8'h02);
      rchk(3'h2, 8'h01);
      wr(3'h1, 8'h00);
      for (int i = 0; i < 8; i++) begin
         serial_line_format = {2'b00, 3'($random(seed)), 3'(i)};
         d = 8'($random(seed));
         n = 5 + serial_line_format[1:0];
         p = serial_line_format[3];
         len = 16 * (1 + n + p) + (serial_line_format[2] ? (n == 5 ? 24 : 32) : 16);
         wr(3'h3, serial_line_format);
         fork
            serial_peer_inst.capture(w);
            begin
               wr(3'h0, d);
               @(posedge mclk);
               wr(3'h0, ~d);
            end
         join
         check({7'h0, w[8]}, 8'h00);
         for (int k = 0; k < n; k++)
            check({7'h0, w[24 + 16 * k]}, {7'h0, d[k]});
         if (p == 1)
            check({7'h0, w[24 + 16 * n]}, {7'h0, par(d, serial_line_format)});
         check({6'h0, w[len - 4], w[len + 4]}, 8'h02);
         repeat (160) @(posedge mclk);
      end
      wr(3'h3, 8'h43);
      wr(3'h0, 8'hff);
      repeat (100) @(posedge mclk);
      #1;
      check({7'h0, txd}, 8'h00);
      wr(3'h3, 8'h1b);
      repeat (200) @(posedge mclk);
      wr(3'h1, 8'h05);
      d = 8'($random(seed));
      serial_peer_inst.send({2'b11, ^d, d, 1'b0}, 11);
      repeat (4) @(posedge mclk);
      rchk(3'h2, 8'h04);
      rchk(3'h0, d);
      rchk(3'h2, 8'h01);
      serial_peer_inst.send({2'b11, ~^d, d, 1'b0}, 11);
      repeat (4) @(posedge mclk);
      rchk(3'h2, 8'h06);
      rd(3'h5, v);
      rchk(3'h2, 8'h04);
      rd(3'h0, v);
      wr(3'h1, 8'h08);
      rd(3'h6, v);
      serial_peer_inst.cts_n <= 1'b0;
      repeat (4) @(posedge mclk);
      rchk(3'h2, 8'h00);
      rchk(3'h6, 8'h11);
      rchk(3'h6, 8'h10);
      wr(3'h1, 8'h00);
      wr(3'h4, 8'h15);
      serial_peer_inst.rxd <= 1'b0;
      wr(3'h3, 8'h03);
      rd(3'h6, v);
      d = 8'($random(seed));
      wr(3'h0, d);
      #1;
      check({5'h0, txd, dtr_n, rts_n}, 8'h07);
      repeat (200) @(posedge mclk);
      rchk(3'h0, d);
      rchk(3'h6, 8'h60);
      wr(3'h1, 8'h08);
      wr(3'h4, 8'h17);
      repeat (3) @(posedge mclk);
      rchk(3'h2, 8'h00);
      rd(3'h6, v);
      wr(3'h4, 8'h00);
      serial_peer_inst.rxd <= 1'b1;
      wr(3'h2, 8'h81);
      wr(3'h1, 8'h01);
      serial_peer_inst.send({3'b111, d, 1'b0}, 10);
      v = 8'h00;
      for (int t = 0; t < 800 && v !== 8'hcc; t++)
         rd(3'h2, v);
      check(v, 8'hcc);
      rchk(3'h0, d);
      rchk(3'h2, 8'hc1);
      results();
   end
endmodule : uart_line_modem_control_tb_top
